// [arc_pkg.sv]
package arc_pkg;

  localparam int          WORD_BITS  = 24;
  localparam int          NUM_WORDS  = 25;
  localparam logic [4:0]  ADDR_LIMIT = 5'h19;

  // Word map of the internal register store
  localparam logic [4:0]  OFFS_BASE  = 5'h00;
  localparam logic [4:0]  GAIN_BASE  = 5'h08;
  localparam logic [4:0]  CFG_ADDR   = 5'h10;
  localparam logic [4:0]  SETUP_BASE = 5'h11;

  // Command byte fields
  localparam int          CLASS_POS  = 7;
  localparam int          CH_LSB     = 4;
  localparam int          RW_POS     = 3;
  localparam logic [2:0]  SEL_OFFS   = 3'h1;
  localparam logic [2:0]  SEL_GAIN   = 3'h2;
  localparam logic [2:0]  SEL_CFG    = 3'h3;
  localparam logic [2:0]  SEL_SETUP  = 3'h5;

  // Depth field of the configuration register, setups minus one
  localparam int          DEPTH_LSB  = 12;
  localparam int          DEPTH_BITS = 4;

  // Setup chain geometry for the eight-channel variant
  localparam int          NUM_SETUPS  = 16;
  localparam int          SETUP_BITS  = 12;
  localparam int          CHAIN_BITS  = NUM_SETUPS * SETUP_BITS;
  localparam int          SETUP_WORDS = CHAIN_BITS / WORD_BITS;

  // Reset values
  localparam logic [23:0] RST_OFFS   = 24'h000000;
  localparam logic [23:0] RST_GAIN   = 24'h400000;
  localparam logic [23:0] RST_CFG    = 24'h000040;
  localparam logic [23:0] RST_SETUP  = 24'h000000;
  localparam logic [2:0]  SYNC_IDLE  = 3'h1;

  // Bit counter end values
  localparam logic [4:0]  CMD_LAST   = 5'h07;
  localparam logic [4:0]  WORD_LAST  = 5'h17;

  typedef enum logic [2:0] {
    ARC_ST_CMD,
    ARC_ST_WR,
    ARC_ST_RD_FETCH,
    ARC_ST_RD_LOAD,
    ARC_ST_RD_SHIFT
  } arc_state_t;

  typedef struct packed {
    logic       ok;
    logic [4:0] base;
    logic [3:0] words;
  } arc_dec_t;

  function automatic arc_dec_t arc_decode(input logic [7:0] cmd,
                                          input logic [3:0] depth);
    arc_dec_t   d;
    logic [2:0] ch;
    d  = '0;
    ch = cmd[CH_LSB +: 3];
    case (cmd[2:0])
      SEL_OFFS: begin
        d.ok   = 1'b1;
        d.base = OFFS_BASE + {2'h0, ch};
      end
      SEL_GAIN: begin
        d.ok   = 1'b1;
        d.base = GAIN_BASE + {2'h0, ch};
      end
      SEL_CFG: begin
        d.ok   = (ch == 3'h0);
        d.base = CFG_ADDR;
      end
      SEL_SETUP: begin
        d.ok    = (ch == 3'h0);
        d.base  = SETUP_BASE;
        d.words = {1'b0, depth[3:1]};
      end
      default: d.ok = 1'b0;
    endcase
    if (cmd[CLASS_POS]) begin
      d.ok = 1'b0;
    end
    return d;
  endfunction

  function automatic logic [23:0] arc_init_word(input int idx);
    logic [23:0] v;
    v = RST_SETUP;
    if (idx < 8) begin
      v = RST_OFFS;
    end else if (idx < 16) begin
      v = RST_GAIN;
    end else if (idx == 16) begin
      v = RST_CFG;
    end
    return v;
  endfunction

endpackage

// [arc_regmem.sv]
`timescale 1ns/100ps
module arc_regmem (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic [4:0]  rd_addr,
  output logic      [23:0] rd_data,
  input  wire logic        wr_en,
  input  wire logic [4:0]  wr_addr,
  input  wire logic [23:0] wr_data
);

  typedef struct packed {
    logic [arc_pkg::NUM_WORDS-1:0][23:0] mem;
    logic [23:0]                         rdata;
  } arc_mem_t;

  arc_mem_t st;
  arc_mem_t next_st;

  always_comb begin
    next_st = st;
    if (wr_en && (wr_addr < arc_pkg::ADDR_LIMIT)) begin
      next_st.mem[wr_addr] = wr_data;
    end
    if (rd_addr < arc_pkg::ADDR_LIMIT) begin
      next_st.rdata = st.mem[rd_addr];
    end else begin
      next_st.rdata = '0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < arc_pkg::NUM_WORDS; i++) begin
        st.mem[i] <= arc_pkg::arc_init_word(i);
      end
      st.rdata <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data = st.rdata;

endmodule

// [adc_register_access_commands.sv]
`timescale 1ns/100ps
// What this block does
// - Target code 010 reaches the chosen gain register; code 111 is eighth.
// - Read/write flag 0 stores the following host data in the register.
// - Read/write flag 1 shifts the register contents out to the host.
// - Target code 101 with channel zero reaches the setup chain at its first word.
// - Setup transfers move only the levels set by the depth field.
// - The setup chain is 192 bits, sixteen 12-bit setups in eight words, for 8 channels only.
// - Class bit set means conversion or calibration, never register access.
module adc_register_access_commands (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       sclk,
  input  wire logic       sdi,
  input  wire logic       cs_n,
  output logic            sdo,
  output logic            conv_strobe,
  output logic      [6:0] conv_command
);

  typedef struct packed {
    logic [2:0]          sync1;
    logic [2:0]          sync2;
    logic                sclk_d;
    arc_pkg::arc_state_t state;
    logic [7:0]          cmd;
    logic [4:0]          bitcnt;
    logic [4:0]          addr;
    logic [3:0]          words;
    logic [23:0]         shreg;
    logic [3:0]          depth;
    logic                wr_en;
    logic [4:0]          wr_addr;
    logic [23:0]         wr_data;
    logic                sdo;
    logic                conv_strobe;
    logic [6:0]          conv_command;
  } arc_top_t;

  arc_top_t          st;
  arc_top_t          next_st;
  logic [23:0]       rd_data;
  logic              sdi_s;
  logic              csn_s;
  logic              rise;
  logic              fall;
  logic [7:0]        cmd_byte;
  logic              dec_now;
  arc_pkg::arc_dec_t dec;

  // Synchronised pins and serial clock edges
  assign sdi_s    = st.sync2[1];
  assign csn_s    = st.sync2[0];
  assign rise     = st.sync2[2] & ~st.sclk_d;
  assign fall     = ~st.sync2[2] & st.sclk_d;
  assign cmd_byte = {st.cmd[6:0], sdi_s};
  assign dec      = arc_pkg::arc_decode(cmd_byte, st.depth);
  assign dec_now  = !csn_s && rise && (st.state == arc_pkg::ARC_ST_CMD) &&
                    (st.bitcnt == arc_pkg::CMD_LAST);

  always_comb begin
    next_st             = st;
    next_st.sync1       = {sclk, sdi, cs_n};
    next_st.sync2       = st.sync1;
    next_st.sclk_d      = st.sync2[2];
    next_st.wr_en       = 1'b0;
    next_st.conv_strobe = 1'b0;
    if (csn_s) begin
      next_st.state  = arc_pkg::ARC_ST_CMD;
      next_st.bitcnt = '0;
    end else begin
      case (st.state)
        arc_pkg::ARC_ST_CMD: begin
          if (rise) begin
            next_st.cmd    = cmd_byte;
            next_st.bitcnt = st.bitcnt + 5'h01;
            if (st.bitcnt == arc_pkg::CMD_LAST) begin
              next_st.bitcnt = '0;
              if (cmd_byte[arc_pkg::CLASS_POS]) begin
                // Conversion request passed on, no register decode
                next_st.conv_strobe  = 1'b1;
                next_st.conv_command = cmd_byte[6:0];
              end else if (dec.ok) begin
                // Select target word
                next_st.addr  = dec.base;
                next_st.words = dec.words;
                if (cmd_byte[arc_pkg::RW_POS]) begin
                  next_st.state = arc_pkg::ARC_ST_RD_FETCH;
                end else begin
                  next_st.state = arc_pkg::ARC_ST_WR;
                end
              end
            end
          end
        end
        arc_pkg::ARC_ST_WR: begin
          if (rise) begin
            next_st.shreg  = {st.shreg[22:0], sdi_s};
            next_st.bitcnt = st.bitcnt + 5'h01;
            if (st.bitcnt == arc_pkg::WORD_LAST) begin
              // Store the finished word
              next_st.bitcnt  = '0;
              next_st.wr_en   = 1'b1;
              next_st.wr_addr = st.addr;
              next_st.wr_data = next_st.shreg;
              if (st.addr == arc_pkg::CFG_ADDR) begin
                next_st.depth =
                  next_st.shreg[arc_pkg::DEPTH_LSB +: arc_pkg::DEPTH_BITS];
              end
              if (st.words == 4'h0) begin
                next_st.state = arc_pkg::ARC_ST_CMD;
              end else begin
                next_st.words = st.words - 4'h1;
                next_st.addr  = st.addr + 5'h01;
              end
            end
          end
        end
        arc_pkg::ARC_ST_RD_FETCH: begin
          next_st.state = arc_pkg::ARC_ST_RD_LOAD;
        end
        arc_pkg::ARC_ST_RD_LOAD: begin
          // Present the MSB before the next rising serial edge
          next_st.shreg  = rd_data;
          next_st.sdo    = rd_data[23];
          next_st.bitcnt = '0;
          next_st.state  = arc_pkg::ARC_ST_RD_SHIFT;
        end
        arc_pkg::ARC_ST_RD_SHIFT: begin
          if (rise) begin
            next_st.bitcnt = st.bitcnt + 5'h01;
            if (st.bitcnt == arc_pkg::WORD_LAST) begin
              next_st.bitcnt = '0;
              if (st.words == 4'h0) begin
                next_st.state = arc_pkg::ARC_ST_CMD;
              end else begin
                next_st.words = st.words - 4'h1;
                next_st.addr  = st.addr + 5'h01;
                next_st.state = arc_pkg::ARC_ST_RD_FETCH;
              end
            end
          end else if (fall && (st.bitcnt != 5'h00)) begin
            next_st.shreg = {st.shreg[22:0], 1'b0};
            next_st.sdo   = st.shreg[22];
          end
        end
        default: next_st.state = arc_pkg::ARC_ST_CMD;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st       <= '0;
      st.sync1 <= arc_pkg::SYNC_IDLE;
      st.sync2 <= arc_pkg::SYNC_IDLE;
    end else begin
      st <= next_st;
    end
  end

  arc_regmem u_mem (
    .mclk    (mclk),
    .reset_n (reset_n),
    .rd_addr (st.addr),
    .rd_data (rd_data),
    .wr_en   (st.wr_en),
    .wr_addr (st.wr_addr),
    .wr_data (st.wr_data)
  );

  assign sdo          = st.sdo;
  assign conv_strobe  = st.conv_strobe;
  assign conv_command = st.conv_command;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence rd_fetch_s;
    st.state == arc_pkg::ARC_ST_RD_FETCH;
  endsequence

  sequence rd_load_s;
    st.state == arc_pkg::ARC_ST_RD_LOAD;
  endsequence

  offs_sel_a: assert property (
    dec_now && !cmd_byte[7] && (cmd_byte[2:0] == 3'h1)
    |=> st.addr == {2'h0, $past(cmd_byte[6:4])})
    else $error("offset command picked wrong word");

  gain_sel_a: assert property (
    dec_now && !cmd_byte[7] && (cmd_byte[2:0] == 3'h2)
    |=> st.addr == 5'h08 + {2'h0, $past(cmd_byte[6:4])})
    else $error("gain command picked wrong word");

  wr_store_a: assert property (
    (st.state == arc_pkg::ARC_ST_WR) && rise && !csn_s &&
    (st.bitcnt == 5'h17)
    |=> st.wr_en && (st.wr_data == {$past(st.shreg[22:0]), $past(sdi_s)}))
    else $error("written word not stored");

  rd_start_a: assert property (
    dec_now && dec.ok && cmd_byte[3] |=> rd_fetch_s ##1 rd_load_s)
    else $error("read command did not fetch");

  rd_load_a: assert property (
    rd_fetch_s ##1 rd_load_s
    |=> (st.shreg == $past(rd_data)) && (sdo == $past(rd_data[23])))
    else $error("read word not loaded to output");

  chain_sel_a: assert property (
    dec_now && (cmd_byte == 8'h05 || cmd_byte == 8'h0d)
    |=> st.addr == 5'h11)
    else $error("setup chain not selected");

  depth_cnt_a: assert property (
    dec_now && (cmd_byte == 8'h05 || cmd_byte == 8'h0d)
    |=> st.words == {1'b0, $past(st.depth[3:1])})
    else $error("setup count not from depth field");

  chain_len_a: assert property (
    (st.words <= 4'h7) && (st.addr <= 5'h18))
    else $error("setup chain overruns its length");

  conv_req_a: assert property (
    dec_now && cmd_byte[7]
    |=> conv_strobe && (conv_command == $past(cmd_byte[6:0])) &&
        (st.state == arc_pkg::ARC_ST_CMD))
    else $error("class bit command decoded as access");

  rsvd_ign_a: assert property (
    dec_now && !cmd_byte[7] && !dec.ok
    |=> (st.state == arc_pkg::ARC_ST_CMD) ##1 !st.wr_en)
    else $error("reserved command not ignored");

  cfg_sel_a: assert property (
    dec_now && (cmd_byte == 8'h03)
    |=> (st.addr == 5'h10) && (st.state == arc_pkg::ARC_ST_WR))
    else $error("configuration command misrouted");

endmodule

// [arc_host.sv]
`timescale 1ns/100ps
module arc_host (
  input  wire logic mclk,
  input  wire logic sdo,
  output logic      sclk,
  output logic      sdi,
  output logic      cs_n
);
  // Serial clock idles low and stands still between frames
  initial begin
    sclk = 1'b0;
    sdi  = 1'b0;
    cs_n = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic start();
    wait_clk(1);
    cs_n = 1'b0;
    wait_clk(8);
  endtask

  // Released data line shows no stale value
  task automatic stop();
    wait_clk(8);
    cs_n = 1'b1;
    sdi  = ~sdi;
  endtask

  // Mode 0, MSB first: sdi moves while sclk is low, sdo taken at the rise
  task automatic shift(input int n, input logic [23:0] d,
                       output logic [23:0] q);
    q = '0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = d[i];
      wait_clk(8);
      sclk = 1'b1;
      q[i] = sdo;
      wait_clk(8);
      sclk = 1'b0;
    end
  endtask
endmodule

// [testbench.sv]
`timescale 1ns/100ps
module testbench;
  logic        mclk;
  logic        reset_n;
  logic        sclk;
  logic        sdi;
  logic        cs_n;
  logic        sdo;
  logic        conv_strobe;
  logic [6:0]  conv_command;
  logic [23:0] wbuf [8];
  logic [23:0] rbuf [8];
  logic [23:0] t;
  logic [2:0]  sel;
  logic [7:0]  resv [6];
  int          n_fail = 0;
  int          n_tests = 0;
  int          n_conv = 0;

  adc_register_access_commands u_dut (
    .mclk(mclk), .reset_n(reset_n), .sclk(sclk), .sdi(sdi), .cs_n(cs_n),
    .sdo(sdo), .conv_strobe(conv_strobe), .conv_command(conv_command));
  arc_host u_host (
    .mclk(mclk), .sdo(sdo), .sclk(sclk), .sdi(sdi), .cs_n(cs_n));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  always @(negedge mclk) begin
    if (conv_strobe === 1'b1) begin
      n_conv++;
    end
  end

  function automatic logic [7:0] acc(input logic [2:0] ch, input logic rw,
                                     input logic [2:0] s);
    return {1'b0, ch, rw, s};
  endfunction

  function automatic logic [23:0] setup_word(input int k, input logic g);
    return {g, 3'(k), 20'h3c5a1};
  endfunction

  task automatic check(input string what, input logic [23:0] exp,
                       input logic [23:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One frame: one or two command bytes, then whole 24-bit words
  task automatic xfer(input logic [15:0] cmds, input int nc, input int nw);
    u_host.start();
    u_host.shift(8 * nc, {8'h00, cmds}, t);
    for (int k = 0; k < nw; k++) begin
      u_host.shift(24, wbuf[k], rbuf[k]);
    end
    u_host.stop();
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge mclk);
    n_fail++;
    give_verdict();
  end

  initial begin
    reset_n = 1'b0;
    resv = '{8'h00, 8'h04, 8'h06, 8'h07, 8'h13, 8'h25};
    repeat (8) @(negedge mclk);
    reset_n = 1'b1;
    repeat (4) @(negedge mclk);
    for (int c = 0; c < 8; c++) begin
      xfer({8'h00, acc(3'(c), 1'b1, arc_pkg::SEL_OFFS)}, 1, 1);
      check("offset reset", 24'h000000, rbuf[0]);
      xfer({8'h00, acc(3'(c), 1'b1, arc_pkg::SEL_GAIN)}, 1, 1);
      check("gain reset", 24'h400000, rbuf[0]);
    end
    xfer(16'h000b, 1, 1);
    check("cfg reset", 24'h000040, rbuf[0]);
    xfer(16'h000d, 1, 1);
    check("setup reset", 24'h000000, rbuf[0]);
    $display("test reset values done");
    for (int c = 0; c < 16; c++) begin
      sel = (c < 8) ? arc_pkg::SEL_OFFS : arc_pkg::SEL_GAIN;
      wbuf[0] = {8'(c), 16'hc35a};
      xfer({8'h00, acc(3'(c), 1'b0, sel)}, 1, 1);
    end
    for (int c = 0; c < 16; c++) begin
      sel = (c < 8) ? arc_pkg::SEL_OFFS : arc_pkg::SEL_GAIN;
      xfer({8'h00, acc(3'(c), 1'b1, sel)}, 1, 1);
      check("channel reg", {8'(c), 16'hc35a}, rbuf[0]);
    end
    $display("test channel registers done");
    for (int r = 0; r < 6; r++) begin
      wbuf[0] = 24'hffffff;
      xfer({resv[r], 8'h0b}, 2, 1);
      check("cfg after reserved", 24'h000040, rbuf[0]);
    end
    $display("test reserved codes done");
    xfer(16'h830b, 2, 1);
    check("cfg after class bit", 24'h000040, rbuf[0]);
    check("conv command", 24'h000003, {17'h0, conv_command});
    xfer(16'h00d5, 1, 0);
    check("conv count", 24'h000002, 24'(n_conv));
    check("conv command", 24'h000055, {17'h0, conv_command});
    $display("test class bit done");
    u_host.start();
    u_host.shift(20, 24'h003abc, t);
    u_host.stop();
    xfer(16'h000b, 1, 1);
    check("cfg after abort", 24'h000040, rbuf[0]);
    $display("test abort done");
    wbuf[0] = 24'h00f040;
    xfer(16'h0003, 1, 1);
    for (int k = 0; k < 8; k++) begin
      wbuf[k] = setup_word(k, 1'b0);
    end
    xfer(16'h0005, 1, 8);
    xfer(16'h000d, 1, 8);
    for (int k = 0; k < 8; k++) begin
      check("setup full", setup_word(k, 1'b0), rbuf[k]);
    end
    wbuf[0] = 24'h003040;
    xfer(16'h0003, 1, 1);
    wbuf[0] = setup_word(0, 1'b1);
    wbuf[1] = setup_word(1, 1'b1);
    xfer(16'h0005, 1, 2);
    wbuf[2] = 24'h0b0000;
    xfer(16'h000d, 1, 3);
    check("setup short", setup_word(0, 1'b1), rbuf[0]);
    check("setup short", setup_word(1, 1'b1), rbuf[1]);
    check("cfg after chain", 24'h000030, {8'h0, rbuf[2][15:0]});
    wbuf[0] = 24'h00f040;
    xfer(16'h0003, 1, 1);
    xfer(16'h000d, 1, 8);
    for (int k = 0; k < 8; k++) begin
      check("setup mixed", setup_word(k, k < 2), rbuf[k]);
    end
    $display("test setup chain done");
    reset_n = 1'b0;
    repeat (2) @(negedge mclk);
    check("conv after reset", 24'h000000, {17'h0, conv_command});
    reset_n = 1'b1;
    repeat (4) @(negedge mclk);
    xfer(16'h000b, 1, 1);
    check("cfg after reset", 24'h000040, rbuf[0]);
    xfer({8'h00, acc(3'h7, 1'b1, arc_pkg::SEL_GAIN)}, 1, 1);
    check("gain after reset", 24'h400000, rbuf[0]);
    xfer(16'h000d, 1, 1);
    check("setup after reset", 24'h000000, rbuf[0]);
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule
